// File: hw/pfsf_top.sv
`timescale 1ns/1ps
`include "pfsf_map.svh"

module pfsf_top import pfsf_pkg::*; #(
  parameter logic [6:0] I2C_ADDR = `PFSF_I2C_ADDR_DEF,
  // arbitrary identifier value
  parameter logic [7:0] DEVICE_IDENTIFIER = `PFSF_DEVICE_IDENTIFIER_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire pfsf_i2c_in_t i2c_in,
  output pfsf_i2c_out_t i2c_out,
  input wire pfsf_pll_t pll,
  input wire logic uvlo,
  input wire logic [7:0] fifo_level,
  input wire logic fifo_new_data,
  input wire logic [7:0] fifo_data,
  input wire logic [7:0] bist_err,
  output logic fifo_rd_pulse,
  output logic shutdown_bit,
  output logic clear_on_data_read,
  output logic [7:0] status_flags,
  output logic irq
);

  pfsf_st_t st_r;
  pfsf_st_t st_nxt;

  logic scl_s;
  logic sda_s;
  logic freq_s;
  logic plock_s;
  logic uv_s;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic afull_hit;
  logic do_load;
  logic do_write;
  logic [4:0] wr_idx;
  logic wr_ok;
  logic [4:0] rd_idx;
  logic rd_ok;
  logic [7:0] rd_val;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [7:0] flags;
  logic [7:0] irq_en1;

  // ----------------------------------------
  // register index lookup
  // ----------------------------------------
  function automatic logic [5:0] reg_index(input logic [7:0] a);
    logic [5:0] r;
    r = 6'h00;
    case (a)
      `PFSF_A_FIFO_THR: r = {1'b1, 5'h00};
      `PFSF_A_FIFO_CFG2: r = {1'b1, 5'h01};
      `PFSF_A_SYS_CFG1: r = {1'b1, 5'h02};
      `PFSF_A_IMP_CFG3: r = {1'b1, 5'h03};
      `PFSF_A_IMP_CFG4: r = {1'b1, 5'h04};
      `PFSF_A_IMP_CFG5: r = {1'b1, 5'h05};
      `PFSF_A_IMP_CFG6: r = {1'b1, 5'h06};
      `PFSF_A_IMP_LO_THR: r = {1'b1, 5'h07};
      `PFSF_A_IMP_HI_THR: r = {1'b1, 5'h08};
      `PFSF_A_IMP_CFG7: r = {1'b1, 5'h09};
      `PFSF_A_MUX_CFG1: r = {1'b1, 5'h0A};
      `PFSF_A_MUX_CFG2: r = {1'b1, 5'h0B};
      `PFSF_A_MUX_CFG3: r = {1'b1, 5'h0C};
      `PFSF_A_DC_LEAD_CFG: r = {1'b1, 5'h0D};
      `PFSF_A_DC_LEAD_THR: r = {1'b1, 5'h0E};
      `PFSF_A_BIAS_CFG: r = {1'b1, 5'h0F};
      `PFSF_A_IRQ_EN1: r = {1'b1, 5'h10};
      `PFSF_A_IRQ_EN2: r = {1'b1, 5'h11};
      default: r = 6'h00;
    endcase
    return r;
  endfunction : reg_index

  // ----------------------------------------
  // synchronised pins and bus events
  // ----------------------------------------
  assign scl_s = st_r.sy2[0];
  assign sda_s = st_r.sy2[1];
  assign freq_s = st_r.sy2[2];
  assign plock_s = st_r.sy2[3];
  assign uv_s = st_r.sy2[4];
  assign scl_rise = scl_s && !st_r.scl_d;
  assign scl_fall = !scl_s && st_r.scl_d;
  assign start_c = scl_s && st_r.scl_d && st_r.sda_d && !sda_s;
  assign stop_c = scl_s && st_r.scl_d && !st_r.sda_d && sda_s;

  assign {wr_ok, wr_idx} = reg_index(st_r.ptr);
  assign {rd_ok, rd_idx} = reg_index(st_r.ptr);
  assign irq_en1 = st_r.regs[5'h10];
  assign clear_on_data_read = st_r.regs[5'h01][`PFSF_B_CLR_ON_RD];
  assign shutdown_bit = st_r.regs[5'h02][`PFSF_B_SHUTDOWN_BIT];
  // level compare, edge taken below so a standing fill sets only once
  assign afull_hit = fifo_level >= st_r.regs[5'h00];

  // ----------------------------------------
  // read data selection
  // ----------------------------------------
  always_comb begin
    case (st_r.ptr)
      `PFSF_A_STATUS: rd_val = flags;
      `PFSF_A_FIFO_DATA: rd_val = fifo_data;
      `PFSF_A_BIST_ERR: rd_val = bist_err;
      `PFSF_A_DEVICE_IDENTIFIER: rd_val = DEVICE_IDENTIFIER;
      default: rd_val = rd_ok ? st_r.regs[rd_idx] : 8'h00;
    endcase
  end

  // ----------------------------------------
  // serial target and register file
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    do_load = 1'b0;
    do_write = 1'b0;
    st_nxt.sy1 = {uvlo, pll.phase_lock, pll.pll_freq_locked_flag, i2c_in.sda, i2c_in.scl};
    st_nxt.sy2 = st_r.sy1;
    st_nxt.warm = {st_r.warm[0], 1'b1}; // cleared sync stages read as unlocked at first
    st_nxt.scl_d = scl_s;
    st_nxt.sda_d = sda_s;
    st_nxt.stat_rd = 1'b0;
    st_nxt.fifo_rd = 1'b0;
    st_nxt.shutdown_bit_wr = 1'b0;
    st_nxt.afull_d = afull_hit;
    if (plock_s) begin
      st_nxt.ever_plock = 1'b1;
    end
    if (start_c) begin
      st_nxt.state = PFSF_ADDR;
      st_nxt.cnt = 4'h0;
      st_nxt.have_ptr = 1'b0;
      st_nxt.drive_low = 1'b0;
    end else if (stop_c) begin
      st_nxt.state = PFSF_IDLE;
      st_nxt.drive_low = 1'b0;
    end else begin
      case (st_r.state)
        PFSF_IDLE: begin
          st_nxt.drive_low = 1'b0;
        end
        PFSF_ADDR: begin
          if (scl_rise) begin
            st_nxt.shift = {st_r.shift[6:0], sda_s};
            st_nxt.cnt = st_r.cnt + 4'h1;
          end else if (scl_fall && st_r.cnt == 4'h8) begin
            if (st_r.shift[7:1] == I2C_ADDR) begin
              st_nxt.drive_low = 1'b1;
              st_nxt.rw = st_r.shift[0];
              st_nxt.state = PFSF_AACK;
            end else begin
              st_nxt.state = PFSF_IDLE;
            end
          end
        end
        PFSF_AACK: begin
          if (scl_fall) begin
            st_nxt.drive_low = 1'b0;
            st_nxt.cnt = 4'h0;
            if (st_r.rw) begin
              do_load = 1'b1;
              st_nxt.state = PFSF_RD;
            end else begin
              st_nxt.state = PFSF_WR;
            end
          end
        end
        PFSF_WR: begin
          if (scl_rise) begin
            st_nxt.shift = {st_r.shift[6:0], sda_s};
            st_nxt.cnt = st_r.cnt + 4'h1;
          end else if (scl_fall && st_r.cnt == 4'h8) begin
            st_nxt.drive_low = 1'b1;
            st_nxt.state = PFSF_WACK;
            if (!st_r.have_ptr) begin
              st_nxt.ptr = st_r.shift;
              st_nxt.have_ptr = 1'b1;
            end else begin
              do_write = 1'b1;
            end
          end
        end
        PFSF_WACK: begin
          if (scl_fall) begin
            st_nxt.drive_low = 1'b0;
            st_nxt.cnt = 4'h0;
            st_nxt.state = PFSF_WR;
          end
        end
        PFSF_RD: begin
          if (scl_fall) begin
            st_nxt.cnt = st_r.cnt + 4'h1;
            st_nxt.tx = {st_r.tx[6:0], 1'b0};
            if (st_r.cnt == 4'h7) begin
              st_nxt.drive_low = 1'b0;
              st_nxt.state = PFSF_RACK;
            end else begin
              st_nxt.drive_low = !st_r.tx[6];
            end
          end
        end
        PFSF_RACK: begin
          if (scl_rise) begin
            st_nxt.more = !sda_s;
          end else if (scl_fall) begin
            if (st_r.more) begin
              do_load = 1'b1;
              st_nxt.state = PFSF_RD;
            end else begin
              st_nxt.state = PFSF_IDLE;
            end
          end
        end
        default: begin
          st_nxt.state = PFSF_IDLE;
        end
      endcase
    end
    // capture happens in the same cycle as the clear pulse is raised
    if (do_load) begin
      st_nxt.tx = rd_val;
      st_nxt.drive_low = !rd_val[7];
      st_nxt.cnt = 4'h0;
      if (st_r.ptr == `PFSF_A_STATUS) begin
        st_nxt.stat_rd = 1'b1;
      end
      // fifo data port does not advance so bursts drain the fifo
      if (st_r.ptr == `PFSF_A_FIFO_DATA) begin
        st_nxt.fifo_rd = 1'b1;
      end else begin
        st_nxt.ptr = st_r.ptr + 8'h01;
      end
    end
    if (do_write) begin
      if (wr_ok) begin
        st_nxt.regs[wr_idx] = st_r.shift;
      end
      if (st_r.ptr == `PFSF_A_SYS_CFG1 && st_r.shift[`PFSF_B_SHUTDOWN_BIT]) begin
        st_nxt.shutdown_bit_wr = 1'b1;
      end
      st_nxt.ptr = st_r.ptr + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  always_comb begin
    set_vec = 8'h00;
    set_vec[`PFSF_B_AFULL] = afull_hit && !st_r.afull_d;
    set_vec[`PFSF_B_DRDY] = fifo_new_data;
    set_vec[`PFSF_B_FLOST] = !freq_s && st_r.warm[1];
    set_vec[`PFSF_B_FLOCK] = freq_s;
    set_vec[`PFSF_B_PLOST] = st_r.ever_plock && !plock_s;
    set_vec[`PFSF_B_PLOCK] = plock_s;
    set_vec[`PFSF_B_UV] = uv_s;
    clr_vec = {8{st_r.stat_rd}};
    clr_vec[`PFSF_B_AFULL] = st_r.stat_rd || (st_r.fifo_rd && clear_on_data_read);
    clr_vec[`PFSF_B_DRDY] = st_r.stat_rd || (st_r.fifo_rd && clear_on_data_read);
    clr_vec[`PFSF_B_UV] = st_r.stat_rd || st_r.shutdown_bit_wr;
  end

  for (genvar i = 0; i < 8; i++) begin : g_flag
    if (i == `PFSF_B_RSVD) begin : g_rsvd
      assign flags[i] = 1'b0;
    end else begin : g_cell
      pfsf_flag_cell #(
        .RST_VAL(1'(`PFSF_STATUS_RST >> i))
      ) u_cell (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .set(set_vec[i]),
        .clr(clr_vec[i]),
        .flag(flags[i])
      );
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // undervoltage bypasses the enables
  assign irq = |(flags & irq_en1) || flags[`PFSF_B_UV];
  assign i2c_out.sda_o = 1'b0;
  assign i2c_out.sda_oe = st_r.drive_low;
  assign fifo_rd_pulse = st_r.fifo_rd;
  assign status_flags = flags;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  afull_reach_a: assert property (afull_hit && !st_r.afull_d |=> flags[7])
    else $error("almost-full did not set");
  afull_stat_a: assert property (st_r.stat_rd && !set_vec[7] |=> !flags[7])
    else $error("almost-full not cleared by status read");
  afull_data_a: assert property (st_r.fifo_rd && clear_on_data_read && !set_vec[7]
    |=> !flags[7]) else $error("almost-full not cleared by data read");
  drdy_set_a: assert property (fifo_new_data |=> flags[5])
    else $error("new-sample flag missed");
  drdy_data_a: assert property (st_r.fifo_rd && clear_on_data_read && !fifo_new_data
    |=> !flags[5]) else $error("new-sample not cleared by data read");
  flost_again_a: assert property (st_r.stat_rd && !freq_s |=> flags[4])
    else $error("frequency-lost not set again");
  flock_hold_a: assert property (freq_s [*2] |=> flags[3])
    else $error("frequency-locked dropped while locked");
  plost_gate_a: assert property (!st_r.ever_plock |=> !flags[2])
    else $error("phase-lost set before any lock");
  plock_again_a: assert property (st_r.stat_rd && plock_s |=> flags[1])
    else $error("phase-locked not set again");
  uv_shutdown_bit_a: assert property (st_r.shutdown_bit_wr && !uv_s |=> !flags[0])
    else $error("undervoltage not cleared by shutdown");
  uv_irq_a: assert property (flags[0] |-> irq)
    else $error("undervoltage did not raise irq");
  irq_mask_a: assert property (irq |-> (|(flags & irq_en1)) || flags[0])
    else $error("irq without an enabled flag");
  stat_capture_a: assert property (st_r.stat_rd |-> st_r.tx == $past(flags))
    else $error("status read lost captured value");

endmodule : pfsf_top

// File: inc/pfsf_map.svh
`ifndef PFSF_MAP_SVH
`define PFSF_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PFSF_A_STATUS 8'h00
`define PFSF_A_FIFO_DATA 8'h0C
`define PFSF_A_FIFO_THR 8'h0D
`define PFSF_A_FIFO_CFG2 8'h0E
`define PFSF_A_SYS_CFG1 8'h11
`define PFSF_A_IMP_CFG3 8'h22
`define PFSF_A_IMP_CFG4 8'h23
`define PFSF_A_IMP_CFG5 8'h24
`define PFSF_A_IMP_CFG6 8'h25
`define PFSF_A_IMP_LO_THR 8'h26
`define PFSF_A_IMP_HI_THR 8'h27
`define PFSF_A_IMP_CFG7 8'h28
`define PFSF_A_MUX_CFG1 8'h41
`define PFSF_A_MUX_CFG2 8'h42
`define PFSF_A_MUX_CFG3 8'h43
`define PFSF_A_BIST_ERR 8'h44
`define PFSF_A_DC_LEAD_CFG 8'h50
`define PFSF_A_DC_LEAD_THR 8'h51
`define PFSF_A_BIAS_CFG 8'h58
`define PFSF_A_IRQ_EN1 8'h80
`define PFSF_A_IRQ_EN2 8'h81
`define PFSF_A_DEVICE_IDENTIFIER 8'hFF

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define PFSF_B_AFULL 7
`define PFSF_B_RSVD 6
`define PFSF_B_DRDY 5
`define PFSF_B_FLOST 4
`define PFSF_B_FLOCK 3
`define PFSF_B_PLOST 2
`define PFSF_B_PLOCK 1
`define PFSF_B_UV 0
`define PFSF_B_CLR_ON_RD 3
`define PFSF_B_SHUTDOWN_BIT 1
`define PFSF_STATUS_RST 8'h01
`define PFSF_CFG_RST 8'h00
`define PFSF_NUM_RW 18
`define PFSF_I2C_ADDR_DEF 7'h30
`define PFSF_DEVICE_IDENTIFIER_DEF 8'h5A

`endif

// File: inc/pfsf_pkg.sv
`include "pfsf_map.svh"

package pfsf_pkg;

  typedef enum logic [2:0] {
    PFSF_IDLE = 3'b000,
    PFSF_ADDR = 3'b001,
    PFSF_AACK = 3'b010,
    PFSF_WR = 3'b011,
    PFSF_WACK = 3'b100,
    PFSF_RD = 3'b101,
    PFSF_RACK = 3'b110
  } pfsf_state_t;

  typedef struct packed {
    logic pll_freq_locked_flag;
    logic phase_lock;
  } pfsf_pll_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } pfsf_i2c_in_t;

  typedef struct packed {
    logic sda_o;
    logic sda_oe;
  } pfsf_i2c_out_t;

  typedef struct packed {
    logic flag;
  } pfsf_cell_t;

  typedef struct packed {
    pfsf_state_t state;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic [7:0] tx;
    logic rw;
    logic have_ptr;
    logic more;
    logic drive_low;
    logic [4:0] sy1;
    logic [4:0] sy2;
    logic scl_d;
    logic sda_d;
    logic afull_d;
    logic ever_plock;
    logic stat_rd;
    logic fifo_rd;
    logic shutdown_bit_wr;
    logic [1:0] warm;
    logic [`PFSF_NUM_RW-1:0][7:0] regs;
  } pfsf_st_t;

endpackage : pfsf_pkg

// File: hw/pfsf_flag_cell.sv
`timescale 1ns/1ps

module pfsf_flag_cell import pfsf_pkg::*; #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic set,
  input wire logic clr,
  output logic flag
);

  pfsf_cell_t st_r;
  pfsf_cell_t st_nxt;

  // set beats clear so an event in the clearing cycle survives
  always_comb begin
    st_nxt = st_r;
    if (set) begin
      st_nxt.flag = 1'b1;
    end else if (clr) begin
      st_nxt.flag = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{flag: RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag = st_r.flag;

  set_wins_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    set |=> flag) else $error("flag lost a set event");

  clear_takes_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clr && !set |=> !flag) else $error("flag did not clear");

endmodule : pfsf_flag_cell

// File: testbench/pfsf_host_model.sv
`timescale 1ns/1ps

module pfsf_host_model (
  input wire logic sys_clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_pull
);
  // scl low time in sys_clk cycles (high time is twice this); the device needs at least 4
  localparam int HALF = 10;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wait_clk

  // ----------------------------------------
  // one scl period: sda a while low, b while high
  // ----------------------------------------
  // a != b gives start (1,0) or stop (0,1); data bits keep a == b
  task automatic phase(input logic a, input logic b, output logic r);
    scl <= 1'b0;
    wait_clk(HALF / 2);
    sda_pull <= ~a;
    wait_clk(HALF / 2);
    scl <= 1'b1;
    wait_clk(HALF);
    r = sda_in;
    sda_pull <= ~b;
    wait_clk(HALF);
  endtask : phase

  // ack slot is always released: device acks, or host gives the final nack
  task automatic xfer(input logic [7:0] d, input logic chk, output logic [7:0] r,
                      inout logic ok);
    logic a;
    for (int i = 7; i >= 0; i--) phase(d[i], d[i], r[i]);
    phase(1'b1, 1'b1, a);
    if (chk) ok = ok & ~a;
  endtask : xfer

  task automatic wr_reg(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d,
                        output logic ok);
    logic [7:0] r;
    logic a;
    ok = 1'b1;
    phase(1'b1, 1'b0, a);
    xfer({dev, 1'b0}, 1'b1, r, ok);
    xfer(ra, 1'b1, r, ok);
    xfer(d, 1'b1, r, ok);
    phase(1'b0, 1'b1, a);
  endtask : wr_reg

  task automatic rd_reg(input logic [6:0] dev, input logic [7:0] ra, output logic [7:0] d,
                        output logic ok);
    logic [7:0] r;
    logic a;
    ok = 1'b1;
    phase(1'b1, 1'b0, a);
    xfer({dev, 1'b0}, 1'b1, r, ok);
    xfer(ra, 1'b1, r, ok);
    phase(1'b1, 1'b0, a);
    xfer({dev, 1'b1}, 1'b1, r, ok);
    xfer(8'hFF, 1'b0, d, ok);
    phase(1'b0, 1'b1, a);
  endtask : rd_reg

  function automatic logic pll_healthy(input logic [7:0] s);
    return s[3] & s[1] & ~s[4];
  endfunction : pll_healthy
endmodule : pfsf_host_model

// File: testbench/tb_top.sv
`timescale 1ns/1ps

module tb_top import pfsf_pkg::*; ();
  localparam logic [6:0] DEV = 7'h30;
  // arbitrary identifier value
  localparam logic [7:0] ID = 8'hC3;
  localparam logic [7:0] RW_MAP [18] = '{8'h0D, 8'h0E, 8'h11, 8'h22, 8'h23, 8'h24, 8'h25,
    8'h26, 8'h27, 8'h28, 8'h41, 8'h42, 8'h43, 8'h50, 8'h51, 8'h58, 8'h80, 8'h81};

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl;
  logic host_pull;
  logic uvlo = 1'b0;
  logic fifo_new_data = 1'b0;
  logic [7:0] fifo_level = 8'h00;
  logic [7:0] fifo_data = 8'h5C;
  logic [7:0] bist_err = 8'h3E;
  pfsf_pll_t pll = 2'b11;
  pfsf_i2c_in_t i2c_in;
  pfsf_i2c_out_t i2c_out;
  logic fifo_rd_pulse;
  logic shutdown_bit;
  logic clear_on_data_read;
  logic irq;
  logic [7:0] status_flags;
  int n_fail = 0;
  int n_compared = 0;
  int n_rd = 0;

  always #4 sys_clk = ~sys_clk;

  // open-drain wire with pull-up
  assign i2c_in = {scl, ~(host_pull | i2c_out.sda_oe)};

  always @(posedge sys_clk) if (fifo_rd_pulse === 1'b1) n_rd++;

  pfsf_top #(.I2C_ADDR(DEV), .DEVICE_IDENTIFIER(ID)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .i2c_in(i2c_in), .i2c_out(i2c_out), .pll(pll),
    .uvlo(uvlo), .fifo_level(fifo_level), .fifo_new_data(fifo_new_data),
    .fifo_data(fifo_data), .bist_err(bist_err), .fifo_rd_pulse(fifo_rd_pulse),
    .shutdown_bit(shutdown_bit), .clear_on_data_read(clear_on_data_read),
    .status_flags(status_flags), .irq(irq)
  );

  pfsf_host_model host_u (
    .sys_clk(sys_clk), .sda_in(i2c_in.sda), .scl(scl), .sda_pull(host_pull)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wait_n

  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    logic ok;
    host_u.wr_reg(DEV, ra, d, ok);
    chk({7'h00, ok}, 8'h01);
  endtask : wr

  task automatic rd(input logic [7:0] ra, input logic [7:0] mask, input logic [7:0] exp);
    logic ok;
    logic [7:0] v;
    host_u.rd_reg(DEV, ra, v, ok);
    chk({7'h00, ok}, 8'h01);
    chk(v & mask, exp);
  endtask : rd

  task automatic new_sample;
    fifo_new_data <= 1'b1;
    wait_n(1);
    fifo_new_data <= 1'b0;
    wait_n(4);
  endtask : new_sample

  task automatic test_done(input string name);
    $display("test %s finished", name);
  endtask : test_done

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // run is about 70k cycles; cut off at 90k
  initial begin
    #720000;
    n_fail++;
    end_of_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic ok;
    wait_n(2);
    chk(status_flags, 8'h01);
    chk({7'h00, irq}, 8'h01);
    wait_n(1);
    rst_n <= 1'b1;
    wait_n(6);
    wr(8'h0D, 8'h04);
    rd(8'h00, 8'h7F, 8'h0B);
    rd(8'h00, 8'hFF, 8'h0A);
    chk({7'h00, irq}, 8'h00);
    chk({7'h00, host_u.pll_healthy(status_flags)}, 8'h01);
    test_done("reset");

    wr(8'h80, 8'h80);
    fifo_level <= 8'h03;
    wait_n(4);
    chk(status_flags & 8'h80, 8'h00);
    fifo_level <= 8'h04;
    wait_n(4);
    chk(status_flags & 8'h80, 8'h80);
    chk({7'h00, irq}, 8'h01);
    rd(8'h00, 8'hFF, 8'h8A);
    chk({7'h00, irq}, 8'h00);
    test_done("almost_full");

    wr(8'h0E, 8'h08);
    chk({7'h00, clear_on_data_read}, 8'h01);
    fifo_level <= 8'h03;
    new_sample();
    fifo_level <= 8'h04;
    wait_n(4);
    chk(status_flags, 8'hAA);
    rd(8'h0C, 8'hFF, 8'h5C);
    chk(status_flags, 8'h0A);
    chk({7'h00, n_rd != 0}, 8'h01);
    wr(8'h0E, 8'h00);
    new_sample();
    rd(8'h0C, 8'hFF, 8'h5C);
    chk(status_flags, 8'h2A);
    rd(8'h00, 8'hFF, 8'h2A);
    chk(status_flags, 8'h0A);
    test_done("fifo_flags");

    wr(8'h80, 8'h10);
    pll.pll_freq_locked_flag <= 1'b0;
    wait_n(6);
    chk({7'h00, irq}, 8'h01);
    rd(8'h00, 8'hFF, 8'h1A);
    rd(8'h00, 8'hFF, 8'h12);
    pll.pll_freq_locked_flag <= 1'b1;
    wait_n(6);
    rd(8'h00, 8'hFF, 8'h1A);
    rd(8'h00, 8'hFF, 8'h0A);
    test_done("pll_freq_locked_flag");

    wr(8'h80, 8'h04);
    pll.phase_lock <= 1'b0;
    wait_n(6);
    chk({7'h00, irq}, 8'h01);
    rd(8'h00, 8'hFF, 8'h0E);
    rd(8'h00, 8'hFF, 8'h0C);
    pll.phase_lock <= 1'b1;
    wait_n(6);
    rd(8'h00, 8'hFF, 8'h0E);
    rd(8'h00, 8'hFF, 8'h0A);
    wr(8'h80, 8'h00);
    test_done("phase_lock");

    uvlo <= 1'b1;
    wait_n(6);
    uvlo <= 1'b0;
    wait_n(6);
    chk(status_flags & 8'h01, 8'h01);
    chk({7'h00, irq}, 8'h01);
    wr(8'h11, 8'h02);
    chk(status_flags & 8'h01, 8'h00);
    chk({7'h00, shutdown_bit}, 8'h01);
    wr(8'h11, 8'h00);
    test_done("undervoltage");

    foreach (RW_MAP[i]) wr(RW_MAP[i], RW_MAP[i] ^ 8'hA5);
    foreach (RW_MAP[i]) rd(RW_MAP[i], 8'hFF, RW_MAP[i] ^ 8'hA5);
    wr(8'h44, 8'hFF);
    rd(8'h44, 8'hFF, 8'h3E);
    wr(8'hFF, 8'h00);
    rd(8'hFF, 8'hFF, ID);
    wr(8'h30, 8'h77);
    rd(8'h30, 8'hFF, 8'h00);
    host_u.wr_reg(7'h31, 8'h80, 8'h00, ok);
    chk({7'h00, ok}, 8'h00);
    rd(8'h80, 8'hFF, 8'h25);
    test_done("register_map");
    end_of_test();
  end
endmodule : tb_top
